// ===== dnr_ddc0_regs.sv
// module: ddc0 nco tuning registers, channel routing and test pattern substitution
// Overview of operation
// (RQ1) Input select bit 0 routes the I path: 0 picks channel A, 1 picks channel B, reset 0.
// (RQ2) Six frequency bytes form a 48-bit signed increment, lowest address holds bits 7:0.
// (RQ3) The increment is added to a 48-bit phase accumulator once per sample.
// (RQ4) Six offset bytes form a 48-bit signed phase offset added to the nco output phase.
// (RQ5) Test enable bit 2 replaces Q samples with the Q test generator pattern, reset 0.
// (RQ6) Test enable bit 0 replaces I samples with the I test generator pattern, reset 0.
// (RQ7) Input select bit 2 routes the Q path: 0 picks channel A/C, 1 picks channel B/D.
// (RQ8) Reserved bits read as zero and writes to them have no effect.
`default_nettype none
module dnr_ddc0_regs #(
  parameter int SAMPLE_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] chanA,
  input wire logic [SAMPLE_W-1:0] chanB,
  input wire logic [SAMPLE_W-1:0] chanC,
  input wire logic [SAMPLE_W-1:0] chanD,
  input wire logic [SAMPLE_W-1:0] testPatI,
  input wire logic [SAMPLE_W-1:0] testPatQ,
  input wire logic [SAMPLE_W-1:0] mixedI,
  input wire logic [SAMPLE_W-1:0] mixedQ,
  output logic [SAMPLE_W-1:0] mixInI,
  output logic [SAMPLE_W-1:0] mixInQ,
  output logic [SAMPLE_W-1:0] outI,
  output logic [SAMPLE_W-1:0] outQ,
  output logic [47:0] freqWord,
  output logic [47:0] phaseOffset,
  output logic [47:0] ncoPhase
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] freq_reg [6];
  logic [7:0] freq_next [6];
  logic [7:0] phase_reg [6];
  logic [7:0] phase_next [6];
  logic [7:0] route_reg;
  logic [7:0] route_next;
  logic [7:0] test_reg;
  logic [7:0] test_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [47:0] freqWord_reg;
  logic [47:0] phaseOfs_reg;
  logic [47:0] incWord;
  logic [47:0] ofsWord;
  logic [47:0] ncoAccum;
  logic [47:0] ncoPhaseRaw;
  logic [SAMPLE_W-1:0] mixInI_reg;
  logic [SAMPLE_W-1:0] mixInI_next;
  logic [SAMPLE_W-1:0] mixInQ_reg;
  logic [SAMPLE_W-1:0] mixInQ_next;
  logic [SAMPLE_W-1:0] outI_reg;
  logic [SAMPLE_W-1:0] outI_next;
  logic [SAMPLE_W-1:0] outQ_reg;
  logic [SAMPLE_W-1:0] outQ_next;

  // byte index of a frequency offset, 6 when not a frequency byte
  function automatic logic [2:0] freqIdx(input logic [11:0] a);
    unique case (a)
      dnr_pkg::FREQ0_OFS: freqIdx = 3'd0;
      dnr_pkg::FREQ1_OFS: freqIdx = 3'd1;
      dnr_pkg::FREQ2_OFS: freqIdx = 3'd2;
      dnr_pkg::FREQ3_OFS: freqIdx = 3'd3;
      dnr_pkg::FREQ4_OFS: freqIdx = 3'd4;
      dnr_pkg::FREQ5_OFS: freqIdx = 3'd5;
      default: freqIdx = 3'd6;
    endcase
  endfunction

  // byte index of a phase offset register, 6 when not one
  function automatic logic [2:0] phaseIdx(input logic [11:0] a);
    unique case (a)
      dnr_pkg::PHASE0_OFS: phaseIdx = 3'd0;
      dnr_pkg::PHASE1_OFS: phaseIdx = 3'd1;
      dnr_pkg::PHASE2_OFS: phaseIdx = 3'd2;
      dnr_pkg::PHASE3_OFS: phaseIdx = 3'd3;
      dnr_pkg::PHASE4_OFS: phaseIdx = 3'd4;
      dnr_pkg::PHASE5_OFS: phaseIdx = 3'd5;
      default: phaseIdx = 3'd6;
    endcase
  endfunction

  // six bytes to one word, lowest index least significant
  function automatic logic [47:0] packWord(input logic [7:0] b [6]);
    logic [47:0] w;
    w = '0;
    for (int k = 0; k < 6; k++) begin
      w[8*k +: 8] = b[k];
    end
    return w;
  endfunction

  // ---------------------------------------------------------------
  // register writes and read mux
  // ---------------------------------------------------------------
  // unmapped reads answer zero; the slave never stalls
  always_comb begin
    logic [2:0] fi;
    logic [2:0] pi;
    fi = freqIdx(regAddr);
    pi = phaseIdx(regAddr);
    freq_next = freq_reg;
    phase_next = phase_reg;
    route_next = route_reg;
    test_next = test_reg;
    rdata_next = 8'h00;
    if (regWrite) begin
      if (fi != 3'd6) begin
        freq_next[fi] = regWdata; // RQ2
      end
      if (pi != 3'd6) begin
        phase_next[pi] = regWdata; // RQ4
      end
      if (regAddr == dnr_pkg::ROUTE_OFS) begin
        route_next = regWdata & dnr_pkg::FIELD_MASK; // RQ8
      end
      if (regAddr == dnr_pkg::TEST_OFS) begin
        test_next = regWdata & dnr_pkg::FIELD_MASK; // RQ8
      end
    end
    if (regRead) begin
      if (fi != 3'd6) begin
        rdata_next = freq_reg[fi];
      end else if (pi != 3'd6) begin
        rdata_next = phase_reg[pi];
      end else if (regAddr == dnr_pkg::ROUTE_OFS) begin
        rdata_next = route_reg;
      end else if (regAddr == dnr_pkg::TEST_OFS) begin
        rdata_next = test_reg;
      end
    end
  end

  // words assembled from bytes, lowest address is least significant
  always_comb begin
    incWord = packWord(freq_reg); // RQ2
    ofsWord = packWord(phase_reg); // RQ4
  end

  // ---------------------------------------------------------------
  // sample path: routing and test substitution
  // ---------------------------------------------------------------
  // the q select names a pair; the pair member is fixed to the upper converter here
  always_comb begin
    mixInI_next = route_reg[dnr_pkg::ROUTE_I_BIT] ? chanB : chanA; // RQ1
    mixInQ_next = route_reg[dnr_pkg::ROUTE_Q_BIT] ? chanD : chanC; // RQ7
    outI_next = test_reg[dnr_pkg::TEST_I_BIT] ? testPatI : mixedI; // RQ6
    outQ_next = test_reg[dnr_pkg::TEST_Q_BIT] ? testPatQ : mixedQ; // RQ5
  end

  // all state registered; outputs come straight from these
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < 6; k++) begin
        freq_reg[k] <= dnr_pkg::BYTE_RST;
        phase_reg[k] <= dnr_pkg::BYTE_RST;
      end
      route_reg <= dnr_pkg::ROUTE_RST;
      test_reg <= dnr_pkg::TEST_RST;
      rdata_reg <= 8'h00;
      freqWord_reg <= dnr_pkg::WORD_RST;
      phaseOfs_reg <= dnr_pkg::WORD_RST;
      mixInI_reg <= '0;
      mixInQ_reg <= '0;
      outI_reg <= '0;
      outQ_reg <= '0;
    end else begin
      freq_reg <= freq_next;
      phase_reg <= phase_next;
      route_reg <= route_next;
      test_reg <= test_next;
      rdata_reg <= rdata_next;
      freqWord_reg <= incWord;
      phaseOfs_reg <= ofsWord;
      mixInI_reg <= mixInI_next;
      mixInQ_reg <= mixInQ_next;
      outI_reg <= outI_next;
      outQ_reg <= outQ_next;
    end
  end

  // ---------------------------------------------------------------
  // nco
  // ---------------------------------------------------------------
  // fed from the registered words: a byte write reaches the nco two cycles later
  dnr_nco_phase #(
    .WIDTH(48)
  ) u_nco (
    .sys_clk(sys_clk),
    .rst(rst),
    .sampleValid(sampleValid),
    .phaseInc(freqWord_reg),
    .phaseOfs(phaseOfs_reg),
    .accum(ncoAccum),
    .phaseOut(ncoPhaseRaw)
  );

  assign regRdata = rdata_reg;
  assign freqWord = freqWord_reg;
  assign phaseOffset = phaseOfs_reg;
  assign ncoPhase = ncoPhaseRaw;
  assign mixInI = mixInI_reg;
  assign mixInQ = mixInQ_reg;
  assign outI = outI_reg;
  assign outQ = outQ_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // routing: one register stage from select bit to mixer input; skip the release edge
  route_i_sel_a: assert property ( // RQ1
    !rst |=> mixInI == ($past(route_reg[0]) ? $past(chanB) : $past(chanA)))
    else $error("I path routing wrong");
  route_q_sel_a: assert property ( // RQ7
    !rst |=> mixInQ == ($past(route_reg[2]) ? $past(chanD) : $past(chanC)))
    else $error("Q path routing wrong");

  // byte placement: a write lands in the assembled word two edges later
  freq_byte_wr_a: assert property ( // RQ2
    regWrite && regAddr == dnr_pkg::FREQ5_OFS |-> ##2 freqWord[47:40] == $past(regWdata, 2))
    else $error("top frequency byte not placed at 47:40");
  freq_low_wr_a: assert property ( // RQ2
    regWrite && regAddr == dnr_pkg::FREQ0_OFS |-> ##2 freqWord[7:0] == $past(regWdata, 2))
    else $error("low frequency byte not placed at 7:0");
  phase_low_wr_a: assert property ( // RQ4
    regWrite && regAddr == dnr_pkg::PHASE0_OFS |-> ##2 phaseOffset[7:0] == $past(regWdata, 2))
    else $error("low offset byte not placed at 7:0");
  phase_top_wr_a: assert property ( // RQ4
    regWrite && regAddr == dnr_pkg::PHASE5_OFS |-> ##2 phaseOffset[47:40] == $past(regWdata, 2))
    else $error("top offset byte not placed at 47:40");

  // nco: the accumulator moves only on a sample
  accum_step_a: assert property ( // RQ3
    sampleValid |=> u_nco.accum_reg == $past(u_nco.accum_reg) + $past(freqWord))
    else $error("accumulator did not step by increment");
  accum_hold_a: assert property ( // RQ3
    !sampleValid |=> $stable(u_nco.accum_reg))
    else $error("accumulator moved without a sample");
  phase_ofs_a: assert property ( // RQ4
    !rst |=> ncoPhase == $past(ncoAccum) + $past(phaseOffset))
    else $error("phase offset not applied");

  // test substitution; output stage is still clear on the release edge
  test_q_sub_a: assert property ( // RQ5
    test_reg[2] |=> outQ == $past(testPatQ))
    else $error("Q test pattern not substituted");
  test_i_sub_a: assert property ( // RQ6
    test_reg[0] |=> outI == $past(testPatI))
    else $error("I test pattern not substituted");
  normal_i_a: assert property ( // RQ6
    !rst && !test_reg[0] |=> outI == $past(mixedI))
    else $error("I normal samples blocked");
  normal_q_a: assert property ( // RQ5
    !rst && !test_reg[dnr_pkg::TEST_Q_BIT] |=> outQ == $past(mixedQ))
    else $error("Q normal samples blocked");

  // reserved bits, read back and unmapped addresses
  reserved_zero_a: assert property ( // RQ8
    (route_reg & ~dnr_pkg::FIELD_MASK) == 8'h00 && (test_reg & ~dnr_pkg::FIELD_MASK) == 8'h00)
    else $error("reserved bits set");
  read_route_a: assert property ( // RQ8
    regRead && regAddr == dnr_pkg::ROUTE_OFS |=> regRdata == $past(route_reg))
    else $error("route read back wrong");
  read_freq_low_a: assert property ( // RQ2
    regRead && regAddr == dnr_pkg::FREQ0_OFS |=> regRdata == $past(freq_reg[0]))
    else $error("low frequency byte read back wrong");
  read_freq_top_a: assert property ( // RQ2
    regRead && regAddr == dnr_pkg::FREQ5_OFS |=> regRdata == $past(freq_reg[5]))
    else $error("top frequency byte read back wrong");
  read_phase_top_a: assert property ( // RQ4
    regRead && regAddr == dnr_pkg::PHASE5_OFS |=> regRdata == $past(phase_reg[5]))
    else $error("top offset byte read back wrong");
  read_test_a: assert property ( // RQ8
    regRead && regAddr == dnr_pkg::TEST_OFS |=> regRdata == $past(test_reg))
    else $error("test enable read back wrong");
  read_idle_a: assert property ( // RQ8
    !regRead |=> regRdata == 8'h00)
    else $error("read data outside a read cycle");
  unmapped_rd_a: assert property ( // RQ8
    regRead && regAddr == 12'h0319 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  unmapped_wr_a: assert property ( // RQ8
    regWrite && regAddr == 12'h0319 |-> ##2 $stable(freqWord))
    else $error("unmapped write changed the increment");

  // main scenarios
  cover property (regWrite && regAddr == dnr_pkg::FREQ5_OFS);
  cover property (route_reg[dnr_pkg::ROUTE_Q_BIT] && !route_reg[dnr_pkg::ROUTE_I_BIT]);
  cover property (test_reg[2] && test_reg[0]);
  cover property (route_reg[0] ##1 !route_reg[0]);
  cover property (sampleValid && freqWord != 48'h0000_0000_0000);
endmodule // dnr_ddc0_regs
`default_nettype wire

// ===== dnr_ddc0_regs_tb.sv
// testbench: register access, routing, test substitution and nco stepping of ddc0 slice
`default_nettype none
module dnr_ddc0_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] regAddr = 12'h0000;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic sampleValid = 1'b0;
  logic [15:0] chanA = 16'h1A1A, chanB = 16'h2B2B, chanC = 16'h3C3C, chanD = 16'h4D4D;
  logic [15:0] patI = 16'h5E5E, patQ = 16'h6F6F, mixI = 16'h7070, mixQ = 16'h8181;
  logic [7:0] regRdata;
  logic [15:0] mixInI, mixInQ, outI, outQ;
  logic [47:0] freqWord, phaseOffset, ncoPhase, expF, expP;
  logic [11:0] ofs [12];
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  // ---------------------------------------------------------------
  // clock, reset and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #50 sysClk = ~sysClk;
  end
  // ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  dnr_ddc0_regs DUT (.sys_clk(sysClk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sampleValid(sampleValid),
    .chanA(chanA), .chanB(chanB), .chanC(chanC), .chanD(chanD), .testPatI(patI),
    .testPatQ(patQ), .mixedI(mixI), .mixedQ(mixQ), .mixInI(mixInI), .mixInQ(mixInQ),
    .outI(outI), .outQ(outQ), .freqWord(freqWord), .phaseOffset(phaseOffset),
    .ncoPhase(ncoPhase));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sysClk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sysClk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sysClk);
    regRead <= 1'b0;
    #1;
    chk({40'h0, regRdata}, {40'h0, exp});
  endtask
  // let the write land in the registers and then in the output stage
  task automatic settle();
    repeat (2) @(posedge sysClk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ofs = '{dnr_pkg::FREQ0_OFS, dnr_pkg::FREQ1_OFS, dnr_pkg::FREQ2_OFS, dnr_pkg::FREQ3_OFS,
      dnr_pkg::FREQ4_OFS, dnr_pkg::FREQ5_OFS, dnr_pkg::PHASE0_OFS, dnr_pkg::PHASE1_OFS,
      dnr_pkg::PHASE2_OFS, dnr_pkg::PHASE3_OFS, dnr_pkg::PHASE4_OFS, dnr_pkg::PHASE5_OFS};
    repeat (6) @(posedge sysClk);
    rst <= 1'b0;
    // every register and field starts cleared
    for (int i = 0; i < 12; i++) begin
      rd(ofs[i], dnr_pkg::BYTE_RST);
    end
    rd(dnr_pkg::ROUTE_OFS, dnr_pkg::ROUTE_RST);
    rd(dnr_pkg::TEST_OFS, dnr_pkg::TEST_RST);
    #1;
    chk({32'h0, mixInI}, {32'h0, chanA});
    chk({32'h0, outI}, {32'h0, mixI});
    chk({32'h0, outQ}, {32'h0, mixQ});
    // bytes apply one at a time, each to its own slice of the word
    expF = dnr_pkg::WORD_RST;
    expP = dnr_pkg::WORD_RST;
    for (int i = 0; i < 6; i++) begin
      expF[8*i +: 8] = 8'hF0 - 8'(i * 8'h22);
      expP[8*i +: 8] = 8'h11 * 8'(i + 1);
      wr(ofs[i], expF[8*i +: 8]);
      settle();
      chk(freqWord, expF);
      wr(ofs[i + 6], expP[8*i +: 8]);
      settle();
      chk(phaseOffset, expP);
      rd(ofs[i], expF[8*i +: 8]);
      rd(ofs[i + 6], expP[8*i +: 8]);
    end
    // gap address between the top two increment bytes is unmapped
    wr(12'h0319, 8'hAA);
    rd(12'h0319, 8'h00);
    settle();
    chk(freqWord, expF);
    // reserved bits of routing and test registers stay zero
    wr(dnr_pkg::ROUTE_OFS, 8'hFF);
    rd(dnr_pkg::ROUTE_OFS, dnr_pkg::FIELD_MASK);
    #1;
    chk({32'h0, mixInI}, {32'h0, chanB});
    chk({32'h0, mixInQ}, {32'h0, chanD});
    wr(dnr_pkg::ROUTE_OFS, 8'h04);
    settle();
    chk({32'h0, mixInI}, {32'h0, chanA});
    chk({32'h0, mixInQ}, {32'h0, chanD});
    wr(dnr_pkg::ROUTE_OFS, 8'h01);
    settle();
    chk({32'h0, mixInI}, {32'h0, chanB});
    chk({32'h0, mixInQ}, {32'h0, chanC});
    wr(dnr_pkg::TEST_OFS, 8'hFA);
    rd(dnr_pkg::TEST_OFS, 8'h00);
    wr(dnr_pkg::TEST_OFS, 8'h01);
    settle();
    chk({32'h0, outI}, {32'h0, patI});
    chk({32'h0, outQ}, {32'h0, mixQ});
    wr(dnr_pkg::TEST_OFS, 8'h04);
    settle();
    chk({32'h0, outI}, {32'h0, mixI});
    chk({32'h0, outQ}, {32'h0, patQ});
    // accumulator idle so far: phase is the offset alone
    chk(ncoPhase, expP);
    // five samples of a large increment wrap the 48-bit phase
    @(posedge sysClk);
    sampleValid <= 1'b1;
    repeat (5) @(posedge sysClk);
    sampleValid <= 1'b0;
    repeat (3) @(posedge sysClk);
    #1;
    chk(ncoPhase, expF * 48'd5 + expP);
    end_of_test();
  end
endmodule // dnr_ddc0_regs_tb
`default_nettype wire

// ===== dnr_nco_phase.sv
// module: 48-bit nco phase accumulator with phase offset
`default_nettype none
module dnr_nco_phase #(
  parameter int WIDTH = 48
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [WIDTH-1:0] phaseInc,
  input wire logic [WIDTH-1:0] phaseOfs,
  output logic [WIDTH-1:0] accum,
  output logic [WIDTH-1:0] phaseOut
);
  logic [WIDTH-1:0] accum_reg;
  logic [WIDTH-1:0] accum_next;
  logic [WIDTH-1:0] phase_reg;
  logic [WIDTH-1:0] phase_next;

  // one increment per sample; wraps modulo 2^48 so fout = inc*fs/2^48
  always_comb begin
    accum_next = accum_reg;
    if (sampleValid) begin
      accum_next = accum_reg + phaseInc; // RQ3
    end
    phase_next = accum_reg + phaseOfs; // RQ4
  end

  // registers only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accum_reg <= '0;
      phase_reg <= '0;
    end else begin
      accum_reg <= accum_next;
      phase_reg <= phase_next;
    end
  end

  assign accum = accum_reg;
  assign phaseOut = phase_reg;
endmodule // dnr_nco_phase
`default_nettype wire

// ===== dnr_pkg.sv
// package: register map, field positions and reset values for the ddc0 nco tuning slice
`default_nettype none
package dnr_pkg;
  localparam int ADDR_W = 12;
  localparam int WORD_W = 48;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] ROUTE_OFS = 12'h0311;
  localparam logic [11:0] FREQ0_OFS = 12'h0314;
  localparam logic [11:0] FREQ1_OFS = 12'h0315;
  localparam logic [11:0] FREQ2_OFS = 12'h0316;
  localparam logic [11:0] FREQ3_OFS = 12'h0317;
  localparam logic [11:0] FREQ4_OFS = 12'h0318;
  localparam logic [11:0] FREQ5_OFS = 12'h031a;
  localparam logic [11:0] PHASE0_OFS = 12'h031d;
  localparam logic [11:0] PHASE1_OFS = 12'h031e;
  localparam logic [11:0] PHASE2_OFS = 12'h031f;
  localparam logic [11:0] PHASE3_OFS = 12'h0320;
  localparam logic [11:0] PHASE4_OFS = 12'h0321;
  localparam logic [11:0] PHASE5_OFS = 12'h0322;
  localparam logic [11:0] TEST_OFS = 12'h0327;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ROUTE_I_BIT = 0;
  localparam int ROUTE_Q_BIT = 2;
  localparam int TEST_I_BIT = 0;
  localparam int TEST_Q_BIT = 2;
  localparam logic [7:0] FIELD_MASK = 8'h05;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [47:0] WORD_RST = 48'h0000_0000_0000;
endpackage : dnr_pkg
`default_nettype wire
